// >>> host_bus_pkg.sv
// Shared constants for the host configuration port.
// Assumes every user writes host_bus_pkg::name; nothing imports it.
`default_nettype none

package host_bus_pkg;

  // Width of the shared address/data lines
  localparam int BUS_W        = 8;
  // Configuration store geometry
  localparam int STORE_ADDR_W = 7;
  localparam int STORE_DATA_W = 8;

  // Strapped interface style on host_mode
  localparam logic [1:0] MODE_SERIAL = 2'h0;
  localparam logic [1:0] MODE_LATCH  = 2'h1;
  localparam logic [1:0] MODE_STROBE = 2'h2;

  // Serial frame: command byte, then data byte (write) or
  // one turnaround byte and then the data byte (read)
  localparam int SER_CNT_W           = 5;
  localparam logic [4:0] SER_CMD_END = 5'h07;
  localparam logic [4:0] SER_WR_END  = 5'h0f;
  localparam logic [4:0] SER_RD_LOAD = 5'h0f;
  localparam logic [4:0] SER_RD_END  = 5'h17;
  // Command bit 7 set means read
  localparam int SER_RD_BIT          = 7;

  // Reset value of the read registers; stored bytes have no reset
  localparam logic [7:0] DATA_RST = 8'h00;

endpackage

`default_nettype wire

// >>> cfg_store.sv
// Small configuration memory with a registered read port.
// Assumes a single requester per cycle on the clk domain.
`timescale 1ns/1ps
`default_nettype none

module cfg_store #(
  parameter int ADDR_W = host_bus_pkg::STORE_ADDR_W,
  parameter int DATA_W = host_bus_pkg::STORE_DATA_W
) (
  input  wire logic              clk,   // System clock
  input  wire logic              nrst,  // Async reset, active low
  input  wire logic              en,    // Access this cycle
  input  wire logic              we,    // Write when set, else read
  input  wire logic [ADDR_W-1:0] addr,  // Word address
  input  wire logic [DATA_W-1:0] wdata, // Write data
  output logic      [DATA_W-1:0] rdata  // Read data, one cycle late
);

  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] next_rdata;

  // Array has no reset; only the read register does
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  // Read register holds its value between reads
  always_comb begin
    next_rdata = rdata;
    if (en && !we) begin
      next_rdata = mem[addr];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= host_bus_pkg::DATA_RST;
    end else begin
      rdata <= next_rdata;
    end
  end

endmodule

`default_nettype wire

// >>> serial_port.sv
// Serial shift engine, clocked by the host shift clock.
// Assumes the shift clock runs only inside a chip-select frame and
// that req_rdata is stable by the turnaround byte's end.
`timescale 1ns/1ps
`default_nettype none

module serial_port (
  input  wire logic       shift_clk,         // Host shift clock
  input  wire logic       nrst,              // Async reset, active low
  input  wire logic       chip_sel_n,        // Frame select, active low
  input  wire logic       serial_in_line,    // Serial data from host
  input  wire logic       shift_edge_select, // High: shift out on fall
  input  wire logic [7:0] req_rdata,         // Read data from clk side
  output logic            req_tgl,           // Toggles per access
  output logic            req_rd,            // Access is a read
  output logic      [6:0] req_addr,          // Access address
  output logic      [7:0] req_wdata,         // Write data
  output logic            serial_out_line,   // Serial data to host
  output logic            serial_out_oe_n    // Output enable, low drives
);

  logic       frame_rst_n;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [7:0] rx_sh, next_rx_sh;
  logic       is_read, next_is_read;
  logic [7:0] tx_sh, next_tx_sh;
  logic       tx_on, next_tx_on;
  logic       out_fall;
  logic       next_req_tgl, next_req_rd;
  logic [6:0] next_req_addr;
  logic [7:0] next_req_wdata;
  logic       edge_meta, edge_sel;

  // Frame state clears whenever the host deselects the port
  assign frame_rst_n = nrst & ~chip_sel_n;

  // Input capture on each rising shift edge
  always_comb begin
    next_rx_sh   = {rx_sh[6:0], serial_in_line};
    next_bit_cnt = bit_cnt;
    next_is_read = is_read;
    next_tx_sh   = tx_sh;
    next_tx_on   = tx_on;
    if (bit_cnt != host_bus_pkg::SER_RD_END) begin
      next_bit_cnt = bit_cnt + 5'h01;
    end
    if (bit_cnt == host_bus_pkg::SER_CMD_END) begin
      next_is_read = next_rx_sh[host_bus_pkg::SER_RD_BIT];
    end
    if (tx_on) begin
      next_tx_sh = {tx_sh[6:0], 1'b0};
    end
    // Turnaround byte gives the clk side time to fetch the word
    if (is_read && bit_cnt == host_bus_pkg::SER_RD_LOAD) begin
      next_tx_sh = req_rdata;
      next_tx_on = 1'b1;
    end
  end

  always_ff @(posedge shift_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      bit_cnt <= 5'h00;
      rx_sh   <= 8'h00;
      is_read <= 1'b0;
      tx_sh   <= 8'h00;
      tx_on   <= 1'b0;
    end else begin
      bit_cnt <= next_bit_cnt;
      rx_sh   <= next_rx_sh;
      is_read <= next_is_read;
      tx_sh   <= next_tx_sh;
      tx_on   <= next_tx_on;
    end
  end

  // Requests survive the frame end so the clk side can see them
  always_comb begin
    next_req_tgl   = req_tgl;
    next_req_rd    = req_rd;
    next_req_addr  = req_addr;
    next_req_wdata = req_wdata;
    if (chip_sel_n == 1'b0) begin
      if (bit_cnt == host_bus_pkg::SER_CMD_END && next_is_read) begin
        next_req_tgl  = ~req_tgl;
        next_req_rd   = 1'b1;
        next_req_addr = next_rx_sh[6:0];
      end
      if (bit_cnt == host_bus_pkg::SER_CMD_END && !next_is_read) begin
        next_req_addr = next_rx_sh[6:0];
      end
      if (bit_cnt == host_bus_pkg::SER_WR_END && !is_read) begin
        next_req_tgl   = ~req_tgl;
        next_req_rd    = 1'b0;
        next_req_wdata = next_rx_sh;
      end
    end
  end

  always_ff @(posedge shift_clk or negedge nrst) begin
    if (!nrst) begin
      req_tgl   <= 1'b0;
      req_rd    <= 1'b0;
      req_addr  <= 7'h00;
      req_wdata <= 8'h00;
      edge_meta <= 1'b0;
      edge_sel  <= 1'b0;
    end else begin
      req_tgl   <= next_req_tgl;
      req_rd    <= next_req_rd;
      req_addr  <= next_req_addr;
      req_wdata <= next_req_wdata;
      edge_meta <= shift_edge_select;
      edge_sel  <= edge_meta;
    end
  end

  // Falling-edge copy; a half period later than the rising copy
  always_ff @(negedge shift_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      out_fall <= 1'b0;
    end else begin
      out_fall <= tx_sh[7];
    end
  end

  // Host samples on the opposite edge of the one chosen here
  assign serial_out_line = edge_sel ? out_fall : tx_sh[7];
  assign serial_out_oe_n = chip_sel_n | ~tx_on;

endmodule

`default_nettype wire

// >>> host_bus_interface.sv
// Host configuration port: serial or multiplexed parallel access
// to a small configuration store.
// Assumes host_mode is strapped and stable, and that pins are
// asynchronous to clk; shift_clk is its own domain.
// Reset must span two clk edges.
//
// Notes on behaviour
// - Latch-enable style: address taken at falling edge of address latch.
// - Strobe style: address taken at falling edge of address strobe.
// - Serial: input line sampled on every rising shift clock edge.
// - Latch-enable style: store strobe low starts a write; bus sampled.
// - Serial output shifts on falling edge if select high, else rising.
// - Strobe style: acknowledge low means read data valid or write taken.
// - Latch-enable style: ready low while busy, high when done.
// - Latch-enable style: read data driven while fetch strobe is low.
// - Strobe style: data strobe writes when direction 0, reads when 1.
// - Eight shared lines carry address first, then data, both ways.
`timescale 1ns/1ps
`default_nettype none

module host_bus_interface (
  input  wire logic       clk,                // System clock, 40 MHz
  input  wire logic       nrst,               // Async reset, active low
  input  wire logic [1:0] host_mode,          // Strapped interface style
  input  wire logic       chip_sel_n,         // Chip select, active low
  input  wire logic       addr_latch_en,      // Latch-enable address latch
  input  wire logic       fetch_n,            // Read strobe, active low
  input  wire logic       store_n,            // Write strobe, active low
  input  wire logic       moto_addr_strobe,   // Address strobe
  input  wire logic       moto_data_strobe_n, // Data strobe, active low
  input  wire logic       moto_rw_sel,        // High read, low write
  input  wire logic [7:0] ad_in,              // Shared lines, pin level
  output logic      [7:0] ad_out,             // Shared lines, drive value
  output logic            ad_oe_n,            // Low while device drives
  output logic            bus_ready,          // Low while busy
  output logic            moto_ack_n,         // Low on acknowledge
  input  wire logic       shift_clk,          // Serial shift clock
  input  wire logic       serial_in_line,     // Serial data in
  input  wire logic       shift_edge_select,  // Serial output edge select
  output logic            serial_out_line,    // Serial data out
  output logic            serial_out_oe_n     // Low while driving
);

  localparam int PIN_W = 18;
  // Idle pin levels: no false edge after reset
  localparam logic [PIN_W-1:0] PIN_IDLE = 18'h1cfff;

  typedef enum logic [2:0] {
    P_IDLE,
    P_WR_BUSY,
    P_RD_WAIT,
    P_RD_HOLD,
    P_DONE
  } par_state_t;

  // Pin synchronisers: first stage read only by the second
  logic [PIN_W-1:0] pin_meta, pin_sync, pin_prev;
  logic [PIN_W-1:0] pins_raw;

  // Pin levels and edges
  logic       cs_act, ale_s, adr_s, rd_n_s, wr_n_s, dat_n_s, rw_s;
  logic       ser_tgl_s, ser_tgl_prev;
  logic [1:0] mode_s;
  logic [7:0] ad_s;
  logic       ale_fall, adr_fall, rd_fall, wr_fall, dat_fall;
  logic       mode_le, mode_ms, mode_ser;

  // Parallel sequencer
  par_state_t state, next_state;
  logic [7:0] addr_q, next_addr_q;
  logic [7:0] next_ad_out;

  // From the shift clock domain
  logic       ser_rd;
  logic [6:0] ser_addr;
  logic [7:0] ser_wdata;
  logic       ser_tgl;
  logic       ser_req;

  // Store port
  logic       mem_en, mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata;
  logic [7:0] ser_rdata, next_ser_rdata;
  logic       ser_rd_pend, next_ser_rd_pend;

  // Data phase of either style
  logic       strobe_start, strobe_read, strobe_released;
  logic       par_wr, par_rd;

  // Pins and the serial toggle
  assign pins_raw = {ser_tgl, host_mode, chip_sel_n, addr_latch_en,
                     moto_addr_strobe, fetch_n, store_n,
                     moto_data_strobe_n, moto_rw_sel, ad_in};

  // Two stages before any logic; third stage for edge detection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
      pin_prev <= PIN_IDLE;
    end else begin
      pin_meta <= pins_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Settled pin levels
  assign ser_tgl_s    = pin_sync[17];
  assign ser_tgl_prev = pin_prev[17];
  assign mode_s       = pin_sync[16:15];
  assign cs_act       = ~pin_sync[14];
  assign ale_s        = pin_sync[13];
  assign adr_s        = pin_sync[12];
  assign rd_n_s       = pin_sync[11];
  assign wr_n_s       = pin_sync[10];
  assign dat_n_s      = pin_sync[9];
  assign rw_s         = pin_sync[8];
  assign ad_s         = pin_sync[7:0];

  // Falling edges; lines and strobes share latency so data lines up
  assign ale_fall = pin_prev[13] & ~ale_s;
  assign adr_fall = pin_prev[12] & ~adr_s;
  assign rd_fall  = pin_prev[11] & ~rd_n_s;
  assign wr_fall  = pin_prev[10] & ~wr_n_s;
  assign dat_fall = pin_prev[9]  & ~dat_n_s;

  // Mode 3 leaves every style idle
  assign mode_le  = (mode_s == host_bus_pkg::MODE_LATCH);
  assign mode_ms  = (mode_s == host_bus_pkg::MODE_STROBE);
  assign mode_ser = (mode_s == host_bus_pkg::MODE_SERIAL);

  // Unified data-phase view of both parallel styles
  always_comb begin
    strobe_start    = 1'b0;
    strobe_read     = 1'b0;
    strobe_released = 1'b1;
    if (mode_le) begin
      strobe_start    = rd_fall | wr_fall;
      strobe_read     = rd_fall;
      strobe_released = rd_n_s & wr_n_s;
    end else if (mode_ms) begin
      strobe_start    = dat_fall;
      strobe_read     = rw_s;
      strobe_released = dat_n_s;
    end
  end

  // Parallel access sequencer
  always_comb begin
    next_state  = state;
    next_addr_q = addr_q;
    next_ad_out = ad_out;
    par_wr      = 1'b0;
    par_rd      = 1'b0;
    // Address phase precedes data on the shared lines
    if (cs_act && mode_le && ale_fall) begin
      next_addr_q = ad_s;
    end
    if (cs_act && mode_ms && adr_fall) begin
      next_addr_q = ad_s;
    end
    // One access at a time
    case (state)
      P_IDLE: begin
        if (cs_act && strobe_start) begin
          if (strobe_read) begin
            par_rd     = 1'b1;
            next_state = P_RD_WAIT;
          end else begin
            par_wr     = 1'b1;
            next_state = P_WR_BUSY;
          end
        end
      end
      P_WR_BUSY: begin
        // Store took the word
        next_state = P_DONE;
      end
      P_RD_WAIT: begin
        // Store answers a cycle late
        next_ad_out = mem_rdata;
        next_state  = P_RD_HOLD;
      end
      P_RD_HOLD, P_DONE: begin
        if (strobe_released) begin
          next_state = P_IDLE;
        end
      end
      default: begin
        next_state = P_IDLE;
      end
    endcase
    // Deselect abandons any access in flight
    if (!cs_act) begin
      next_state = P_IDLE;
    end
  end

  // Sequencer registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state  <= P_IDLE;
      addr_q <= 8'h00;
      ad_out <= host_bus_pkg::DATA_RST;
    end else begin
      state  <= next_state;
      addr_q <= next_addr_q;
      ad_out <= next_ad_out;
    end
  end

  // Lines are released as soon as the fetch or data strobe lifts
  assign ad_oe_n = ~(cs_act && state == P_RD_HOLD &&
                     !strobe_released);
  // Ready dips for one cycle
  assign bus_ready = ~(mode_le &&
                       (state == P_WR_BUSY || state == P_RD_WAIT));
  // Acknowledge holds until strobe lifts
  assign moto_ack_n = ~(mode_ms &&
                        (state == P_DONE || state == P_RD_HOLD));

  // Serial access arrives as a toggle from the shift clock domain
  // A new frame must start five cycles after the last
  assign ser_req = mode_ser && (ser_tgl_s != ser_tgl_prev);

  // Store port: only the strapped style may reach it
  always_comb begin
    mem_en    = 1'b0;
    mem_we    = 1'b0;
    mem_addr  = addr_q[6:0];
    mem_wdata = ad_s;
    // Serial side owns the port
    if (mode_ser) begin
      mem_en    = ser_req;
      mem_we    = ~ser_rd;
      mem_addr  = ser_addr;
      mem_wdata = ser_wdata;
    end else begin
      mem_en = par_wr | par_rd;
      mem_we = par_wr;
    end
  end

  // Serial read word, held stable for the shift domain to load
  always_comb begin
    next_ser_rd_pend = ser_req & ser_rd;
    next_ser_rdata   = ser_rdata;
    if (ser_rd_pend) begin
      next_ser_rdata = mem_rdata;
    end
  end

  // Serial read registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ser_rd_pend <= 1'b0;
      ser_rdata   <= host_bus_pkg::DATA_RST;
    end else begin
      ser_rd_pend <= next_ser_rd_pend;
      ser_rdata   <= next_ser_rdata;
    end
  end

  // Store, read data a cycle late
  cfg_store #(
    .ADDR_W (host_bus_pkg::STORE_ADDR_W),
    .DATA_W (host_bus_pkg::STORE_DATA_W)
  ) u_store (
    .clk   (clk),
    .nrst  (nrst),
    .en    (mem_en),
    .we    (mem_we),
    .addr  (mem_addr),
    .wdata (mem_wdata),
    .rdata (mem_rdata)
  );

  // Shift engine; address and data words are stable around the toggle
  serial_port u_serial (
    .shift_clk         (shift_clk),
    .nrst              (nrst),
    .chip_sel_n        (chip_sel_n),
    .serial_in_line    (serial_in_line),
    .shift_edge_select (shift_edge_select),
    .req_rdata         (ser_rdata),
    .req_tgl           (ser_tgl),
    .req_rd            (ser_rd),
    .req_addr          (ser_addr),
    .req_wdata         (ser_wdata),
    .serial_out_line   (serial_out_line),
    .serial_out_oe_n   (serial_out_oe_n)
  );

endmodule

`default_nettype wire

// >>> host_bus_sva.sv
// Checker for the host configuration port, bound to its top module.
// Assumes the host keeps each strobe low until the answer is seen.
`timescale 1ns/1ps
`default_nettype none

module host_bus_sva (
  input wire logic       clk,                // System clock
  input wire logic       nrst,               // Async reset, active low
  input wire logic [1:0] host_mode,          // Strapped style
  input wire logic       chip_sel_n,         // Chip select
  input wire logic       fetch_n,            // Read strobe
  input wire logic       store_n,            // Write strobe
  input wire logic       moto_data_strobe_n, // Data strobe
  input wire logic       moto_rw_sel,        // High read
  input wire logic       ad_oe_n,            // Bus drive enable
  input wire logic       bus_ready,          // Low while busy
  input wire logic       moto_ack_n,         // Acknowledge
  input wire logic       shift_clk,          // Serial shift clock
  input wire logic       shift_edge_select,  // Output edge select
  input wire logic       serial_out_line,    // Serial data out
  input wire logic       serial_out_oe_n     // Serial drive enable
);
  logic so_rise;
  logic oe_rise;
  logic so_fall;
  logic oe_fall;

  // Output captured at each shift edge, to see on which edge it moves
  always_ff @(posedge shift_clk or negedge nrst) begin
    if (!nrst) begin
      so_rise <= 1'b0;
      oe_rise <= 1'b1;
    end else begin
      so_rise <= serial_out_line;
      oe_rise <= serial_out_oe_n;
    end
  end
  always_ff @(negedge shift_clk or negedge nrst) begin
    if (!nrst) begin
      so_fall <= 1'b0;
      oe_fall <= 1'b1;
    end else begin
      so_fall <= serial_out_line;
      oe_fall <= serial_out_oe_n;
    end
  end

  // Busy lasts one cycle; acknowledge must outlive the strobe sync
  sequence busy_pulse;
    !bus_ready ##1 bus_ready;
  endsequence
  sequence ack_hold;
    !moto_ack_n [*2];
  endsequence

  AST_RDY_BUSY_ONE: assert property (@(posedge clk) disable iff (!nrst)
    $fell(bus_ready) |-> busy_pulse) else $error("ready pulse wrong");
  AST_RDY_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
    $fell(bus_ready) |-> !chip_sel_n && (!store_n || !fetch_n))
    else $error("busy without strobe");
  AST_RDY_BEFORE_DRIVE: assert property (@(posedge clk)
    disable iff (!nrst) $fell(ad_oe_n) && host_mode == 2'h1
    |-> $past(bus_ready) == 1'b0) else $error("read data without busy");
  AST_DRIVE_CAUSE: assert property (@(posedge clk) disable iff (!nrst)
    $fell(ad_oe_n) |-> !chip_sel_n
    && (!fetch_n || (!moto_data_strobe_n && moto_rw_sel)))
    else $error("bus driven without read");
  AST_ACK_LATENCY: assert property (@(posedge clk) disable iff (!nrst)
    $fell(moto_data_strobe_n) && !chip_sel_n && host_mode == 2'h2
    |-> ##[2:5] !moto_ack_n) else $error("acknowledge late");
  AST_ACK_STANDS: assert property (@(posedge clk) disable iff (!nrst)
    $fell(moto_ack_n) |-> ack_hold) else $error("acknowledge too short");
  AST_ACK_WITH_DATA: assert property (@(posedge clk)
    disable iff (!nrst) $fell(moto_ack_n) && moto_rw_sel |-> !ad_oe_n)
    else $error("read acknowledge without data");
  AST_IDLE_DESELECTED: assert property (@(posedge clk)
    disable iff (!nrst) chip_sel_n [*4] |-> ad_oe_n && moto_ack_n
    && bus_ready && serial_out_oe_n) else $error("active while deselected");
  AST_SO_FALL_EDGE: assert property (@(negedge shift_clk)
    disable iff (!nrst) shift_edge_select && !serial_out_oe_n && !oe_rise
    |-> serial_out_line == so_rise) else $error("output moved on rise");
  AST_SO_RISE_EDGE: assert property (@(posedge shift_clk)
    disable iff (!nrst) !shift_edge_select && !serial_out_oe_n && !oe_fall
    |-> serial_out_line == so_fall) else $error("output moved on fall");
endmodule

bind host_bus_interface host_bus_sva u_host_bus_sva (
  .clk(clk), .nrst(nrst), .host_mode(host_mode), .chip_sel_n(chip_sel_n),
  .fetch_n(fetch_n), .store_n(store_n),
  .moto_data_strobe_n(moto_data_strobe_n), .moto_rw_sel(moto_rw_sel),
  .ad_oe_n(ad_oe_n), .bus_ready(bus_ready), .moto_ack_n(moto_ack_n),
  .shift_clk(shift_clk), .shift_edge_select(shift_edge_select),
  .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n));

`default_nettype wire

// >>> serial_host.sv
// Model of the serial host: frames, shift clock and data line.
// Assumes the bench calls frame() only while serial mode is strapped.
`timescale 1ns/1ps
`default_nettype none

module serial_host (
  output logic       shift_clk, // Runs only inside a frame
  output logic       cs_n,      // Frame select, active low
  output logic       dout,      // Data to the device
  input  wire logic  edge_sel,  // High: device shifts out on fall
  input  wire logic  din,       // Data from the device
  output logic [7:0] rd_byte,   // Last byte read
  output logic       rd_seen    // Toggles after each read frame
);
  initial begin
    shift_clk = 1'b0;
    cs_n = 1'b1;
    dout = 1'b0;
    rd_byte = 8'h00;
    rd_seen = 1'b0;
  end

  // One frame, 32 ns shift period; stall stops the clock between bytes
  task automatic frame(input logic rd, input logic [6:0] a,
                       input logic [7:0] d, input int stall);
    logic [23:0] sh;
    sh = {rd, a, d, 8'h00};
    cs_n = 1'b0;
    #40;
    for (int i = 0; i < (rd ? 24 : 16); i++) begin
      dout = sh[23-i];
      #8;
      if (edge_sel && i >= 16) rd_byte = {rd_byte[6:0], din};
      shift_clk = 1'b1;
      #16;
      if (!edge_sel && i >= 15 && i < 23) rd_byte = {rd_byte[6:0], din};
      shift_clk = 1'b0;
      #8;
      if (i == 7 || i == 15) #(stall);
    end
    // Released line shows the inverse, never a stale level
    dout = ~dout;
    #40;
    cs_n = 1'b1;
    if (rd) rd_seen = ~rd_seen;
    #200;
  endtask
endmodule

`default_nettype wire

// >>> test_host_bus_interface.sv
// Bench for the host configuration port: both parallel styles driven
// here, serial frames from the serial host model.
// Assumes store contents are undefined, so only written bytes are read.
`timescale 1ns/1ps
`default_nettype none

module test_host_bus_interface;
  logic       clk, nrst, par_cs_n, ser_cs_n, addr_latch_en, fetch_n;
  logic       store_n, moto_addr_strobe, moto_data_strobe_n, moto_rw_sel;
  logic       host_drv, ad_oe_n, bus_ready, moto_ack_n, shift_clk;
  logic       serial_in_line, shift_edge_select, serial_out_line;
  logic       serial_out_oe_n, rd_seen, oe_last;
  logic [1:0] host_mode;
  logic [7:0] host_ad, float_pat, ad_out, rd_byte, rnd;
  logic [7:0] mem [0:127];
  logic [6:0] addrs [0:3];
  logic [7:0] par_q [$];
  logic [7:0] ser_q [$];
  int         failures, check_count;
  wire logic       chip_sel_n = par_cs_n & ser_cs_n;
  wire logic [7:0] ad_in = !ad_oe_n ? ad_out : (host_drv ? host_ad : float_pat);
  // Released serial line reads inverted
  wire logic out_pin = serial_out_oe_n ? ~serial_out_line : serial_out_line;

  host_bus_interface u_host_bus_interface (.clk(clk), .nrst(nrst),
    .host_mode(host_mode), .chip_sel_n(chip_sel_n),
    .addr_latch_en(addr_latch_en), .fetch_n(fetch_n), .store_n(store_n),
    .moto_addr_strobe(moto_addr_strobe), .moto_rw_sel(moto_rw_sel),
    .moto_data_strobe_n(moto_data_strobe_n), .ad_in(ad_in),
    .ad_out(ad_out), .ad_oe_n(ad_oe_n), .bus_ready(bus_ready),
    .moto_ack_n(moto_ack_n), .shift_clk(shift_clk),
    .serial_in_line(serial_in_line), .shift_edge_select(shift_edge_select),
    .serial_out_line(serial_out_line), .serial_out_oe_n(serial_out_oe_n));
  serial_host u_serial_host (.shift_clk(shift_clk), .cs_n(ser_cs_n),
    .dout(serial_in_line), .edge_sel(shift_edge_select),
    .din(out_pin), .rd_byte(rd_byte), .rd_seen(rd_seen));

  // 40 MHz clock; undriven bus lines wander every cycle
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    float_pat = 8'h5a;
    forever @(posedge clk) float_pat <= ~float_pat;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, g);
    chk_byte(nm, {7'h00, e}, {7'h00, g});
  endtask
  // Bounded wait: 0 ready, 1 acknowledge, 2 bus drive enable
  task automatic wait_lvl(input int s, input logic lvl);
    int n;
    n = 0;
    while (n < 20 && (s == 0 ? bus_ready : s == 1 ? moto_ack_n : ad_oe_n)
           !== lvl) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      $display("wrong value wait %0d expected %b seen timeout", s, lvl);
      failures++;
      results();
    end
    check_count++;
  endtask

  // One parallel access in the strapped style; sel low keeps deselected
  task automatic par_op(input logic rd, sel, input logic [6:0] a,
                        input logic [7:0] d);
    logic lat;
    lat = (host_mode == host_bus_pkg::MODE_LATCH);
    tick(1);
    par_cs_n = !sel;
    host_drv = 1'b1;
    host_ad = {d[7], a};
    addr_latch_en = lat;
    moto_addr_strobe = !lat;
    tick(4);
    addr_latch_en = 1'b0;
    moto_addr_strobe = 1'b0;
    tick(4);
    host_ad = d;
    host_drv = !rd;
    moto_rw_sel = rd;
    tick(1);
    if (rd && sel) par_q.push_back(mem[a]);
    if (!rd && sel) mem[a] = d;
    fetch_n = !(lat && rd);
    store_n = !(lat && !rd);
    moto_data_strobe_n = lat;
    if (!sel) tick(8);
    else if (lat) begin
      wait_lvl(0, 1'b0);
      wait_lvl(0, 1'b1);
    end else wait_lvl(1, 1'b0);
    tick(2);
    fetch_n = 1'b1;
    store_n = 1'b1;
    moto_data_strobe_n = 1'b1;
    wait_lvl(2, 1'b1);
    wait_lvl(1, 1'b1);
    par_cs_n = 1'b1;
    host_drv = 1'b0;
    tick(4);
  endtask

  // Monitors take the oldest note whenever read data appears
  always @(negedge clk) begin
    if (oe_last === 1'b1 && ad_oe_n === 1'b0) begin
      if (par_q.size() == 0) chk_bit("bus drive", 1'b1, ad_oe_n);
      else chk_byte("parallel read", par_q.pop_front(), ad_out);
    end
    oe_last = ad_oe_n;
  end
  always @(rd_seen) begin
    if (nrst === 1'b1) chk_byte("serial read", ser_q.pop_front(), rd_byte);
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    host_mode = host_bus_pkg::MODE_LATCH;
    {par_cs_n, fetch_n, store_n, moto_data_strobe_n} = 4'hf;
    {addr_latch_en, moto_addr_strobe, moto_rw_sel, host_drv} = 4'h0;
    host_ad = 8'h00;
    shift_edge_select = 1'b0;
    rnd = 8'h2f;
    failures = 0;
    check_count = 0;
    tick(5);
    chk_bit("reset drive", 1'b1, ad_oe_n);
    chk_bit("reset ready", 1'b1, bus_ready);
    chk_bit("reset ack", 1'b1, moto_ack_n);
    chk_bit("reset serial drive", 1'b1, serial_out_oe_n);
    nrst = 1'b1;
    tick(4);
    for (int m = 1; m <= 2; m++) begin
      host_mode = m[1:0];
      tick(4);
      for (int i = 0; i < 4; i++) begin
        rnd = lfsr(rnd);
        addrs[i] = rnd[6:0];
        rnd = lfsr(rnd);
        par_op(1'b0, 1'b1, addrs[i], rnd);
      end
      for (int i = 0; i < 4; i++) par_op(1'b1, 1'b1, addrs[i], 8'h00);
    end
    host_mode = host_bus_pkg::MODE_LATCH;
    par_op(1'b0, 1'b0, addrs[0], ~mem[addrs[0]]);
    par_op(1'b1, 1'b1, addrs[0], 8'h00);
    host_mode = host_bus_pkg::MODE_SERIAL;
    tick(4);
    for (int e = 0; e < 2; e++) begin
      shift_edge_select = e[0];
      rnd = lfsr(rnd);
      u_serial_host.frame(1'b0, addrs[1], rnd, e * 300);
      mem[addrs[1]] = rnd;
      ser_q.push_back(rnd);
      u_serial_host.frame(1'b1, addrs[1], 8'h00, e * 300);
      ser_q.push_back(mem[addrs[2]]);
      u_serial_host.frame(1'b1, addrs[2], 8'h00, 0);
    end
    host_mode = host_bus_pkg::MODE_STROBE;
    tick(4);
    par_op(1'b1, 1'b1, addrs[1], 8'h00);
    tick(10);
    results();
  end
endmodule

`default_nettype wire
